//--- logic/pmm_consts.vh
// Purpose: shared constants of the program memory map and overlay block
// Assumes: 16-bit program address, 8-bit configuration register port
// Notes:   definitions only
`ifndef PMM_CONSTS_VH
`define PMM_CONSTS_VH

// register port addresses
`define CFG_ADDR        8'hB1
`define STAT_ADDR       8'hBF

// flash configuration register fields and reset value
`define CFG_VIS_BIT     7
`define CFG_MAP_HI      1
`define CFG_MAP_LO      0
`define CFG_WMASK       8'h83
`define CFG_RESET       8'h00

// overlay size encodings
`define MAP_OFF         2'h0
`define MAP_1K          2'h1
`define MAP_2K          2'h2
`define MAP_4K          2'h3
`define NV_OFF          2'h3

// address map
`define PRI_BASE        16'h0000
`define SEC_BASE        16'hF000
`define OVL_1K_END      16'h03FF
`define OVL_2K_END      16'h07FF
`define OVL_4K_END      16'h0FFF
`define SEC_TOP_NIBBLE  4'hF

// flash organisation
`define PRI_ROW_BYTES   64
`define SEC_ROW_BYTES   32
`define SEC_SECTORS     64

// security lock levels
`define LOCK_L2         3'h2
`define LOCK_L3         3'h3
`define LOCK_L4         3'h4

// fetch target encodings
`define SEL_NONE        2'h0
`define SEL_PRI         2'h1
`define SEL_SEC         2'h2
`define SEL_EXT         2'h3

// timing counts in core clocks, reset pin hold count in machine cycles
`define MC_CLKS         4'hC
`define ALE_DIV         3'h6
`define RST_MC          2'h2

`endif

//--- logic/ale_strobe_gen.v
// Purpose: address latch strobe at one sixth of the clock with skip
// Assumes: clk_i is the crystal rate, skip_i is a same-domain pulse
// Notes:   a pending skip eats exactly the next pulse
`timescale 1ns/1ps
`default_nettype none
`include "pmm_consts.vh"
module ale_strobe_gen #(
    parameter [2:0] DIV = `ALE_DIV
) (
    // clock and reset
    input  wire clk_i,
    input  wire rst_n_i,
    // control
    input  wire run_i,
    input  wire skip_i,
    // strobe
    output reg  ale_pulse_o
);
    reg  [2:0] cnt_ff;
    reg        skip_pend_ff;
    wire       tick;

    assign tick = run_i && (cnt_ff == DIV - 3'h1);

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff       <= 3'h0;
            skip_pend_ff <= 1'b0;
            ale_pulse_o  <= 1'b0;
        end else begin
            if (!run_i || tick)
                cnt_ff <= 3'h0;
            else
                cnt_ff <= cnt_ff + 3'h1;
            ale_pulse_o <= tick && !skip_pend_ff;
            // a new skip request wins over consuming the old one
            if (skip_i)
                skip_pend_ff <= 1'b1;
            else if (tick)
                skip_pend_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- logic/fetch_decoder.v
// Purpose: registered decode of one program or data access
// Assumes: request is a same-domain one-cycle strobe
// Notes:   answer appears in the cycle after the request
`timescale 1ns/1ps
`default_nettype none
`include "pmm_consts.vh"
module fetch_decoder #(
    parameter PRIMARY_KB = 32
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // request
    input  wire        req_i,
    input  wire [15:0] addr_i,
    input  wire        code_i,
    // configuration
    input  wire        internal_i,
    input  wire        lock4_i,
    input  wire        sec_vis_i,
    input  wire [1:0]  map_i,
    // answer
    output reg         valid_o,
    output reg  [1:0]  sel_o,
    output reg  [15:0] phys_o,
    output reg  [7:0]  sector_o,
    output reg         row_o,
    output reg  [5:0]  byte_o
);
    localparam [31:0] PRI_END_W = PRIMARY_KB * 1024 - 1;
    localparam [15:0] PRI_END   = PRI_END_W[15:0];

    function ovl_hit;
        input [1:0]  map;
        input [15:0] a;
        begin
            case (map)
                `MAP_1K: ovl_hit = (a <= `OVL_1K_END);
                `MAP_2K: ovl_hit = (a <= `OVL_2K_END);
                `MAP_4K: ovl_hit = (a <= `OVL_4K_END);
                default: ovl_hit = 1'b0;
            endcase
        end
    endfunction

    reg        ovl;
    reg [15:0] la;
    reg [1:0]  sel;

    always @* begin
        ovl = code_i && internal_i && ovl_hit(map_i, addr_i);
        la  = ovl ? {`SEC_TOP_NIBBLE, addr_i[11:0]} : addr_i;
        sel = `SEL_EXT;
        if (code_i && internal_i) begin
            if (!ovl && la <= PRI_END)
                sel = `SEL_PRI;
            else if (la >= `SEC_BASE && (ovl || sec_vis_i))
                sel = `SEL_SEC;
            else if (lock4_i)
                sel = `SEL_NONE;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_o  <= 1'b0;
            sel_o    <= `SEL_NONE;
            phys_o   <= 16'h0000;
            sector_o <= 8'h00;
            row_o    <= 1'b0;
            byte_o   <= 6'h00;
        end else begin
            valid_o <= req_i;
            if (req_i) begin
                sel_o  <= sel;
                phys_o <= la;
                if (sel == `SEL_SEC) begin
                    sector_o <= {2'h0, la[11:6]};
                    row_o    <= la[5];
                    byte_o   <= {1'b0, la[4:0]};
                end else begin
                    sector_o <= la[14:7];
                    row_o    <= la[6];
                    byte_o   <= la[5:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/program_memory_map_remap.v
// Purpose: program fetch decoder, overlay control, reset pin and strobes
// Assumes: clk_i is the crystal rate, machine cycle is twelve clocks
// Notes:   pins are synchronised, core-side ports are same-domain
//
// Summary of operation
// - reset pin high two machine cycles with clock running resets device.
// - strobe pin falling while reset held selects host programming mode.
// - strap low fetches externally, strap high executes from internal flash.
// - lock level 4 ignores strap, internal execution only.
// - lock levels 2/3 skip strap latch; strap rising switches to internal.
// - address latch strobe driven so external logic latches low address.
// - latch strobe pulses at one sixth of crystal rate in normal operation.
// - exactly one latch strobe pulse skipped per external data access.
// - during programming the latch strobe pin is an input pulse.
// - primary block 16 or 32 KByte from 0000H to 3FFFH or 7FFFH.
// - secondary block 4 KByte decoded at F000H through FFFFH.
// - primary block is 128/256 sectors of two 64-byte rows.
// - secondary block is 64 sectors of two 32-byte rows.
// - with internal execution the primary block is fetchable outside the overlaid range.
// - native secondary range fetchable only while config bit 7 set.
// - full overlay forces top four bits high below 1000H.
// - overlaid primary part is unreachable by fetches.
// - during overlay secondary answers the low range, and the native range only while config bit 7 set.
// - overlay field 00 off, 01 1K, 10 2K, 11 4K.
// - overlay field in config bits 1:0, writable; zero disables at once.
// - each reset loads field from inverted nonvolatile bits; copies independent.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmm_consts.vh"
module program_memory_map_remap #(
    parameter PRIMARY_KB = 32
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        resetn_i,
    // device pins
    input  wire        rst_pin_i,
    input  wire        external_fetch_select_i,
    input  wire        program_store_strobe_i,
    output reg         program_store_strobe_o,
    output reg         program_store_strobe_oe_o,
    input  wire        ale_i,
    output reg         ale_o,
    output reg         ale_oe_o,
    // nonvolatile configuration
    input  wire [2:0]  lock_level_i,
    input  wire [1:0]  overlay_nv_bits_i,
    // register port
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    // core access port
    input  wire        fetch_req_i,
    input  wire [15:0] fetch_addr_i,
    input  wire        fetch_code_i,
    input  wire        xdata_req_i,
    output wire        fetch_valid_o,
    output wire [1:0]  fetch_sel_o,
    output wire [15:0] fetch_phys_o,
    output wire [7:0]  sector_o,
    output wire        row_o,
    output wire [5:0]  byte_o,
    // status
    output reg         device_reset_o,
    output reg         host_mode_o,
    output reg         internal_exec_o,
    output reg         program_pulse_in_o
);
    localparam PRI_SECTORS = PRIMARY_KB * 1024 / (2 * `PRI_ROW_BYTES);
    localparam NSYNC       = 4;
    localparam SY_RST      = 0;
    localparam SY_STRAP    = 1;
    localparam SY_PSS      = 2;
    localparam SY_ALE      = 3;

    // reset release
    reg              rst_s1_ff;
    reg              rst_n_ff;
    wire             rst_n;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end
    assign rst_n = rst_n_ff;

    // hold edges and release back until the pin pipeline carries real pin levels
    reg  [2:0]       settle_ff;
    wire             settled;

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            settle_ff <= 3'h0;
        else
            settle_ff <= {settle_ff[1:0], 1'b1};
    end

    assign settled = settle_ff[2];

    // pin synchronisers
    wire [NSYNC-1:0] pin_raw;
    reg  [NSYNC-1:0] sync1_ff;
    reg  [NSYNC-1:0] sync2_ff;
    reg  [NSYNC-1:0] prev_ff;
    wire [NSYNC-1:0] rise;
    wire [NSYNC-1:0] fall;

    assign pin_raw = {ale_i, program_store_strobe_i,
                      external_fetch_select_i, rst_pin_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                    prev_ff[gi]  <= 1'b0;
                end else begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    prev_ff[gi]  <= sync2_ff[gi];
                end
            end
            assign rise[gi] = settled && sync2_ff[gi] && !prev_ff[gi];
            assign fall[gi] = settled && !sync2_ff[gi] && prev_ff[gi];
        end
    endgenerate

    wire rst_hi;
    wire strap;

    assign rst_hi = sync2_ff[SY_RST];
    assign strap  = sync2_ff[SY_STRAP];

    // machine cycle divider
    reg  [3:0] mc_cnt_ff;
    wire       mc_tick;

    assign mc_tick = (mc_cnt_ff == `MC_CLKS - 4'h1);

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            mc_cnt_ff <= 4'h0;
        else if (mc_tick)
            mc_cnt_ff <= 4'h0;
        else
            mc_cnt_ff <= mc_cnt_ff + 4'h1;
    end

    // reset pin qualification and mode entry
    reg  [1:0] rst_mc_ff;
    reg        host_req_ff;
    reg        internal_ff;
    reg  [2:0] lock_ff;
    wire       release_evt;
    wire       lock23;
    wire       lock4;

    assign release_evt = device_reset_o && !rst_hi && settled;
    assign lock23      = (lock_ff == `LOCK_L2) || (lock_ff == `LOCK_L3);
    assign lock4       = (lock_ff == `LOCK_L4);

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rst_mc_ff      <= 2'h0;
            device_reset_o <= 1'b1;
            host_req_ff    <= 1'b0;
            host_mode_o    <= 1'b0;
            internal_ff    <= 1'b0;
            lock_ff        <= 3'h0;
        end else begin
            if (!rst_hi)
                rst_mc_ff <= 2'h0;
            else if (mc_tick && rst_mc_ff != `RST_MC)
                rst_mc_ff <= rst_mc_ff + 2'h1;
            if (rst_hi && rst_mc_ff == `RST_MC)
                device_reset_o <= 1'b1;
            else if (release_evt)
                device_reset_o <= 1'b0;
            if (device_reset_o && rst_hi && fall[SY_PSS])
                host_req_ff <= 1'b1;
            else if (release_evt)
                host_req_ff <= 1'b0;
            if (release_evt) begin
                host_mode_o <= host_req_ff;
                lock_ff     <= lock_level_i;
            end
            if (release_evt) begin
                if (lock_level_i == `LOCK_L2 || lock_level_i == `LOCK_L3)
                    internal_ff <= 1'b0;
                else
                    internal_ff <= strap;
            end else if (lock23 && rise[SY_STRAP]) begin
                internal_ff <= 1'b1;
            end
        end
    end

    wire running;
    wire internal_sel;

    assign running      = !device_reset_o && !host_mode_o;
    assign internal_sel = lock4 || internal_ff;

    // flash configuration register
    reg  [7:0] cfg_ff;
    wire       cfg_wr;

    assign cfg_wr = reg_wr_i && running && (reg_addr_i == `CFG_ADDR);

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= `CFG_RESET;
        end else if (release_evt) begin
            cfg_ff <= `CFG_RESET;
            cfg_ff[`CFG_MAP_HI:`CFG_MAP_LO] <= ~overlay_nv_bits_i;
        end else if (cfg_wr) begin
            cfg_ff <= reg_wdata_i & `CFG_WMASK;
        end
    end

    wire [7:0] stat;

    assign stat = {4'h0, lock4, internal_sel, host_mode_o, device_reset_o};

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `CFG_ADDR:  reg_rdata_o <= cfg_ff;
                `STAT_ADDR: reg_rdata_o <= stat;
                default:    reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // access decode
    wire dec_req;

    assign dec_req = running && (fetch_req_i || xdata_req_i);

    fetch_decoder #(
        .PRIMARY_KB (PRIMARY_KB)
    ) u_dec (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .req_i      (dec_req),
        .addr_i     (fetch_addr_i),
        .code_i     (fetch_code_i && !xdata_req_i),
        .internal_i (internal_sel),
        .lock4_i    (lock4),
        .sec_vis_i  (cfg_ff[`CFG_VIS_BIT]),
        .map_i      (cfg_ff[`CFG_MAP_HI:`CFG_MAP_LO]),
        .valid_o    (fetch_valid_o),
        .sel_o      (fetch_sel_o),
        .phys_o     (fetch_phys_o),
        .sector_o   (sector_o),
        .row_o      (row_o),
        .byte_o     (byte_o)
    );

    // address latch strobe
    wire ale_pulse;

    ale_strobe_gen #(
        .DIV (`ALE_DIV)
    ) u_ale (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n),
        .run_i       (running),
        .skip_i      (running && xdata_req_i),
        .ale_pulse_o (ale_pulse)
    );

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ale_o              <= 1'b0;
            ale_oe_o           <= 1'b0;
            program_pulse_in_o <= 1'b0;
        end else begin
            ale_o              <= ale_pulse;
            ale_oe_o           <= running;
            program_pulse_in_o <= host_mode_o && !device_reset_o
                                  && fall[SY_ALE];
        end
    end

    // the code line may change after the request edge, so keep its value
    reg ext_code_ff;

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            ext_code_ff <= 1'b0;
        else
            ext_code_ff <= fetch_code_i && !xdata_req_i;
    end

    // program store strobe, low for one clock per external code fetch
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            program_store_strobe_o    <= 1'b1;
            program_store_strobe_oe_o <= 1'b0;
        end else begin
            program_store_strobe_oe_o <= running;
            program_store_strobe_o    <= !(fetch_valid_o
                                          && fetch_sel_o == `SEL_EXT
                                          && ext_code_ff);
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            internal_exec_o <= 1'b0;
        else
            internal_exec_o <= running && internal_sel;
    end

endmodule
`default_nettype wire

//--- tb/pmm_asserts.sv
// Purpose: port checks of the program memory map block
// Assumes: one clock, resetn_i async active low
// Notes:   bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "pmm_consts.vh"
module pmm_asserts #(
    parameter PRIMARY_KB = 32
) (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        resetn_i,
    // access port
    input wire logic        fetch_req_i,
    input wire logic        fetch_code_i,
    input wire logic        xdata_req_i,
    input wire logic        fetch_valid_o,
    input wire logic [1:0]  fetch_sel_o,
    input wire logic [15:0] fetch_phys_o,
    input wire logic [7:0]  sector_o,
    input wire logic        row_o,
    input wire logic [5:0]  byte_o,
    // pins and status
    input wire logic        ale_o,
    input wire logic        ale_oe_o,
    input wire logic        program_store_strobe_o,
    input wire logic        program_store_strobe_oe_o,
    input wire logic        device_reset_o,
    input wire logic        host_mode_o,
    input wire logic        internal_exec_o
);
    wire run = !device_reset_o && !host_mode_o;
    wire req = fetch_req_i || xdata_req_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_answer_next:
        assert property (req && run |=> fetch_valid_o) else $error("access not answered");
    a_refused_quiet:
        assert property (!(req && run) |=> !fetch_valid_o) else $error("answer without access");
    a_ale_single:
        assert property (ale_o |=> !ale_o) else $error("latch strobe too wide");
    a_ale_cadence:
        assert property (ale_o && !xdata_req_i && !$past(xdata_req_i) && !$past(xdata_req_i, 2)
            ##1 (!xdata_req_i && ale_oe_o) [*5] |=> ale_o) else $error("latch strobe late");
    a_ale_skip_one:
        assert property (ale_o && !xdata_req_i && !$past(xdata_req_i) ##1 xdata_req_i
            ##1 !xdata_req_i [*4] |=> !ale_o) else $error("latch strobe not skipped");
    a_pins_released:
        assert property ((device_reset_o || host_mode_o) && $past(device_reset_o || host_mode_o)
            |-> !ale_oe_o && !program_store_strobe_oe_o) else $error("pin driven in reset");
    a_strobe_ext_fetch:
        assert property (fetch_req_i && fetch_code_i && !xdata_req_i && run && !internal_exec_o
            |-> ##2 !program_store_strobe_o) else $error("no fetch strobe");
    a_strobe_idle:
        assert property (!fetch_valid_o |=> program_store_strobe_o) else $error("stray strobe");
    a_sec_layout:
        assert property (fetch_valid_o && fetch_sel_o == `SEL_SEC
            |-> fetch_phys_o[15:12] == `SEC_TOP_NIBBLE && sector_o == {2'h0, fetch_phys_o[11:6]}
            && row_o == fetch_phys_o[5] && byte_o == {1'h0, fetch_phys_o[4:0]})
            else $error("secondary decode wrong");
    a_pri_layout:
        assert property (fetch_valid_o && fetch_sel_o == `SEL_PRI
            |-> fetch_phys_o < PRIMARY_KB * 1024 && sector_o == fetch_phys_o[14:7]
            && row_o == fetch_phys_o[6] && byte_o == fetch_phys_o[5:0])
            else $error("primary decode wrong");

    c_secondary: cover property (fetch_valid_o && fetch_sel_o == `SEL_SEC);
    c_host: cover property (host_mode_o);
    c_xdata: cover property (xdata_req_i && ale_oe_o);
endmodule
bind program_memory_map_remap pmm_asserts #(.PRIMARY_KB(PRIMARY_KB)) u_chk (.*);
`default_nettype wire

//--- tb/core_fetch_model.sv
// Purpose: instruction fetch side of the core, one access at a time
// Assumes: answer comes one clock after the request edge
// Notes:   idle address and code lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module core_fetch_model (
    // clock
    input  wire logic        clk_i,
    // answer
    input  wire logic        valid_i,
    input  wire logic [1:0]  sel_i,
    input  wire logic [15:0] phys_i,
    // request
    output var  logic        req_o,
    output var  logic        xdata_o,
    output var  logic        code_o,
    output var  logic [15:0] addr_o
);
    initial begin
        req_o = 1'h0;
        xdata_o = 1'h0;
        code_o = 1'h0;
        addr_o = 16'h0000;
    end
    task automatic access(input logic [15:0] a, input logic c, input logic x,
                          output logic ok, output logic [17:0] ans);
        @(posedge clk_i);
        req_o <= !x;
        xdata_o <= x;
        code_o <= c;
        addr_o <= a;
        @(posedge clk_i);
        req_o <= 1'h0;
        xdata_o <= 1'h0;
        code_o <= ~c;
        addr_o <= ~a;
        #1;
        ok = valid_i;
        ans = {sel_i, phys_i};
    endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench of the program memory map block
// Assumes: 50 MHz clock, smaller primary block variant
// Notes:   expectations come from the bench decode function
`timescale 1ns/1ps
`default_nettype none
`include "pmm_consts.vh"
module tb;
    localparam int PKB = 16;
    logic        clk_i = 1'h0;
    logic        resetn_i = 1'h0;
    logic        rst_pin, strap, program_store_strobe_in, ale_in, rwr, rrd;
    logic [2:0]  lock;
    logic [1:0]  nv, map, fsel;
    logic [7:0]  raddr, wdata, rdata;
    logic        freq, fxd, fcode, fvalid, ale_out, ale_oe;
    logic        dev_rst, host, intl, ppulse, vis, lk4, ext_int;
    logic [15:0] faddr, fphys;
    logic        ok;
    logic [17:0] ans;
    int          miscompares = 0;
    int          check_count = 0;
    int          c;
    logic [15:0] corner [12] = '{16'h0000, 16'h03FF, 16'h0400, 16'h07FF, 16'h0800, 16'h0FFF,
                                 16'h1000, 16'h3FFF, 16'h4000, 16'hEFFF, 16'hF000, 16'hFFFF};
    always #10 clk_i = ~clk_i;

    program_memory_map_remap #(.PRIMARY_KB(PKB)) DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .rst_pin_i(rst_pin),
        .external_fetch_select_i(strap), .program_store_strobe_i(program_store_strobe_in),
        .program_store_strobe_o(), .program_store_strobe_oe_o(), .ale_i(ale_in),
        .ale_o(ale_out), .ale_oe_o(ale_oe), .lock_level_i(lock), .overlay_nv_bits_i(nv),
        .reg_addr_i(raddr), .reg_wdata_i(wdata), .reg_wr_i(rwr), .reg_rd_i(rrd),
        .reg_rdata_o(rdata), .fetch_req_i(freq), .fetch_addr_i(faddr), .fetch_code_i(fcode),
        .xdata_req_i(fxd), .fetch_valid_o(fvalid), .fetch_sel_o(fsel), .fetch_phys_o(fphys),
        .sector_o(), .row_o(), .byte_o(), .device_reset_o(dev_rst), .host_mode_o(host),
        .internal_exec_o(intl), .program_pulse_in_o(ppulse));
    core_fetch_model core (.clk_i(clk_i), .valid_i(fvalid), .sel_i(fsel), .phys_i(fphys),
        .req_o(freq), .xdata_o(fxd), .code_o(fcode), .addr_o(faddr));

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return dev_rst;
            1: return intl;
            2: return host;
            3: return ppulse;
            default: return ale_out;
        endcase
    endfunction
    task automatic wait_sig(input int k, input logic v, input int n);
        for (int i = 0; i < n && sig(k) !== v; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk(sig(k), v);
        if (sig(k) !== v) report_and_stop();
    endtask
    task automatic count(input int k, input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            cnt += sig(k);
        end
    endtask
    task automatic do_reset(input logic [2:0] lk, input logic [1:0] n, input logic s);
        @(posedge clk_i);
        resetn_i <= 1'h0;
        lock <= lk;
        nv <= n;
        strap <= s;
        rst_pin <= 1'h0;
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'h1;
        wait_sig(0, 1'h0, 40);
        @(posedge clk_i);
        #1;
        map = ~n;
        vis = 1'h0;
        lk4 = (lk == `LOCK_L4);
        ext_int = s || lk4;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        raddr <= a;
        wdata <= d;
        rwr <= 1'h1;
        @(posedge clk_i);
        rwr <= 1'h0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        raddr <= a;
        rrd <= 1'h1;
        @(posedge clk_i);
        rrd <= 1'h0;
        #1;
        chk(rdata, exp);
    endtask
    function automatic logic [17:0] dec(input logic [15:0] a, input logic cd);
        if (!cd || !ext_int) return {`SEL_EXT, a};
        if (map != `MAP_OFF && a < (16'h0400 << (map - 2'h1)))
            return {`SEL_SEC, `SEC_TOP_NIBBLE, a[11:0]};
        if (a < PKB * 1024) return {`SEL_PRI, a};
        if (a >= `SEC_BASE && vis) return {`SEL_SEC, a};
        return {lk4 ? `SEL_NONE : `SEL_EXT, a};
    endfunction
    task automatic fchk(input logic [15:0] a, input logic cd);
        logic [17:0] e;
        core.access(a, cd, 1'h0, ok, ans);
        e = dec(a, cd);
        chk(ok, 1'h1);
        chk(ans[17:16], e[17:16]);
        if (e[17:16] != `SEL_NONE) chk(ans[15:0], e[15:0]);
    endtask
    task automatic pin_hold(input int n);
        @(posedge clk_i);
        rst_pin <= 1'h1;
        repeat (n) @(posedge clk_i);
        rst_pin <= 1'h0;
    endtask

    initial begin
        {program_store_strobe_in, ale_in, strap, rst_pin, rwr, rrd} = 6'h3C;
        {lock, nv, raddr, wdata} = 21'h00003;
        void'($urandom(32'h826E));
        for (int n = 0; n < 4; n++) begin
            do_reset(3'h0, n[1:0], 1'h1);
            rchk(`CFG_ADDR, {6'h00, map});
            for (int v = 0; v < 2; v++) begin
                vis = v[0];
                wr(`CFG_ADDR, {vis, 5'h00, map});
                foreach (corner[i]) fchk(corner[i], 1'h1);
                repeat (8) fchk(16'($urandom), 1'($urandom));
            end
        end
        rchk(`STAT_ADDR, 8'h04);
        chk(ale_oe, 1'h1);
        wr(`CFG_ADDR, 8'hFF);
        rchk(`CFG_ADDR, 8'h83);
        wr(`CFG_ADDR, 8'h00);
        {map, vis} = 3'h0;
        fchk(16'h0005, 1'h1);
        for (int k = 0; k < 6; k++) begin
            fork
                count(4, 60, c);
                begin
                    repeat (k) @(posedge clk_i);
                    core.access(16'h1234, 1'h0, 1'h1, ok, ans);
                end
            join
            chk(c, 9);
        end
        count(4, 60, c);
        chk(c, 10);
        wr(`CFG_ADDR, 8'h81);
        nv <= 2'h1;
        rchk(`CFG_ADDR, 8'h81);
        fork
            pin_hold(8);
            count(0, 20, c);
        join
        chk(c, 0);
        fork
            pin_hold(40);
            count(0, 60, c);
        join
        chk(c > 0, 1'h1);
        wait_sig(0, 1'h0, 20);
        rchk(`CFG_ADDR, 8'h02);
        do_reset(3'h0, 2'h3, 1'h0);
        chk(intl, 1'h0);
        fchk(16'h0005, 1'h1);
        do_reset(3'h4, 2'h3, 1'h0);
        chk(intl, 1'h1);
        fchk(16'h8000, 1'h1);
        rchk(`STAT_ADDR, 8'h0C);
        for (int lk = 2; lk < 4; lk++) begin
            do_reset(lk[2:0], 2'h3, 1'h0);
            chk(intl, 1'h0);
            strap <= 1'h1;
            wait_sig(1, 1'h1, 20);
        end
        @(posedge clk_i);
        rst_pin <= 1'h1;
        wait_sig(0, 1'h1, 60);
        program_store_strobe_in <= 1'h0;
        repeat (4) @(posedge clk_i);
        rst_pin <= 1'h0;
        wait_sig(2, 1'h1, 40);
        chk(ale_oe, 1'h0);
        fork
            count(3, 12, c);
            begin
                repeat (2) @(posedge clk_i);
                ale_in <= 1'h0;
                repeat (2) @(posedge clk_i);
                ale_in <= 1'h1;
            end
        join
        chk(c, 1);
        core.access(16'h0005, 1'h1, 1'h0, ok, ans);
        chk(ok, 1'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
